//--- imc_mode_ctrl.sv
// Input mapping, channel drive and low-power mode control
`timescale 1ns/100ps
module imc_mode_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic direct_input_a,
    input wire logic direct_input_b,
    input wire logic low_power_req_n,
    input wire logic [imc_pkg::NUM_PWM-1:0] pwm_gen_out,
    input wire logic [imc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [imc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [imc_pkg::DATA_W-1:0] reg_rdata,
    output logic [imc_pkg::NUM_CH-1:0] channel_drive,
    output logic serial_enable,
    output logic uv_detect_enable,
    output logic [2:0] mode_state
);

    imc_pin_if pin_bus ();

    assign pin_bus.raw[imc_pkg::PIN_A] = direct_input_a;
    assign pin_bus.raw[imc_pkg::PIN_B] = direct_input_b;
    assign pin_bus.raw[imc_pkg::PIN_LP_N] = low_power_req_n;

    imc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .pins(pin_bus)
    );

    // Synchronised pin levels
    logic in_a;
    logic in_b;
    logic lp_n;

    assign in_a = pin_bus.synced[imc_pkg::PIN_A];
    assign in_b = pin_bus.synced[imc_pkg::PIN_B];
    assign lp_n = pin_bus.synced[imc_pkg::PIN_LP_N];

    // Mode selection
    imc_pkg::imc_mode_t mode_reg;
    imc_pkg::imc_mode_t mode_next;

    logic any_input_high;

    assign any_input_high = in_a | in_b;

    always_comb
    begin
        case (mode_reg)
            imc_pkg::MODE_NORMAL,
            imc_pkg::MODE_FALLBACK,
            imc_pkg::MODE_SLEEP:
            begin
                if (lp_n)
                begin
                    mode_next = imc_pkg::MODE_NORMAL;
                end
                else if (any_input_high)
                begin
                    mode_next = imc_pkg::MODE_FALLBACK;
                end
                else
                begin
                    mode_next = imc_pkg::MODE_SLEEP;
                end
            end
            default:
            begin
                mode_next = imc_pkg::MODE_NORMAL;
            end
        endcase
    end

    // Reset loads normal mode, but the synchroniser resets low, so sleep follows until it settles
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_reg <= imc_pkg::MODE_NORMAL;
        end
        else
        begin
            mode_reg <= mode_next;
        end
    end

    logic is_normal;
    logic is_fallback;
    logic is_sleep;

    assign is_normal = (mode_reg == imc_pkg::MODE_NORMAL);
    assign is_fallback = (mode_reg == imc_pkg::MODE_FALLBACK);
    assign is_sleep = (mode_reg == imc_pkg::MODE_SLEEP);

    // Register access decode
    logic bus_live;
    logic wr_ok;
    logic rd_ok;

    // Fallback still answers reads, so the monitor stays visible
    assign bus_live = !is_sleep;
    assign wr_ok = reg_wr & bus_live;
    assign rd_ok = reg_rd & bus_live;

    logic wr_output;
    logic wr_map_a;
    logic wr_map_b;
    logic wr_pwm0;
    logic wr_pwm1;

    assign wr_output = wr_ok & (reg_addr == imc_pkg::OFS_OUTPUT);
    assign wr_map_a = wr_ok & (reg_addr == imc_pkg::OFS_MAP_A);
    assign wr_map_b = wr_ok & (reg_addr == imc_pkg::OFS_MAP_B);
    assign wr_pwm0 = wr_ok & (reg_addr == imc_pkg::OFS_PWM0_MAP);
    assign wr_pwm1 = wr_ok & (reg_addr == imc_pkg::OFS_PWM1_MAP);

    // Writable registers
    logic [imc_pkg::DATA_W-1:0] output_reg;
    logic [imc_pkg::DATA_W-1:0] input_a_channel_map_reg;
    logic [imc_pkg::DATA_W-1:0] input_b_channel_map_reg;
    logic [imc_pkg::DATA_W-1:0] pwm0_map_reg;
    logic [imc_pkg::DATA_W-1:0] pwm1_map_reg;

    logic hold_default;

    // Low pin level forces defaults and beats any write
    assign hold_default = !lp_n;

    logic [imc_pkg::DATA_W-1:0] output_next;
    logic [imc_pkg::DATA_W-1:0] map_a_next;
    logic [imc_pkg::DATA_W-1:0] map_b_next;
    logic [imc_pkg::DATA_W-1:0] pwm0_next;
    logic [imc_pkg::DATA_W-1:0] pwm1_next;

    assign output_next = hold_default ? imc_pkg::RST_OUTPUT :
                         wr_output ? reg_wdata : output_reg;
    assign map_a_next = hold_default ? imc_pkg::RST_MAP_A :
                        wr_map_a ? reg_wdata : input_a_channel_map_reg;
    assign map_b_next = hold_default ? imc_pkg::RST_MAP_B :
                        wr_map_b ? reg_wdata : input_b_channel_map_reg;
    assign pwm0_next = hold_default ? imc_pkg::RST_PWM_MAP :
                       wr_pwm0 ? reg_wdata : pwm0_map_reg;
    assign pwm1_next = hold_default ? imc_pkg::RST_PWM_MAP :
                       wr_pwm1 ? reg_wdata : pwm1_map_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            output_reg <= imc_pkg::RST_OUTPUT;
            input_a_channel_map_reg <= imc_pkg::RST_MAP_A;
            input_b_channel_map_reg <= imc_pkg::RST_MAP_B;
            pwm0_map_reg <= imc_pkg::RST_PWM_MAP;
            pwm1_map_reg <= imc_pkg::RST_PWM_MAP;
        end
        else
        begin
            output_reg <= output_next;
            input_a_channel_map_reg <= map_a_next;
            input_b_channel_map_reg <= map_b_next;
            pwm0_map_reg <= pwm0_next;
            pwm1_map_reg <= pwm1_next;
        end
    end

    // Input level monitor follows the pins in every mode
    logic [imc_pkg::DATA_W-1:0] input_level_monitor;

    always_comb
    begin
        input_level_monitor = imc_pkg::RD_ZERO;
        input_level_monitor[imc_pkg::MON_A_BIT] = in_a;
        input_level_monitor[imc_pkg::MON_B_BIT] = in_b;
    end

    logic [imc_pkg::DATA_W-1:0] mode_status;

    assign mode_status = {5'h00, mode_reg};

    // Read path, data only in the cycle after the strobe
    logic [imc_pkg::DATA_W-1:0] rd_sel;

    always_comb
    begin
        case (reg_addr)
            imc_pkg::OFS_OUTPUT:
            begin
                rd_sel = output_reg;
            end
            imc_pkg::OFS_MAP_A:
            begin
                rd_sel = input_a_channel_map_reg;
            end
            imc_pkg::OFS_MAP_B:
            begin
                rd_sel = input_b_channel_map_reg;
            end
            imc_pkg::OFS_PWM0_MAP:
            begin
                rd_sel = pwm0_map_reg;
            end
            imc_pkg::OFS_PWM1_MAP:
            begin
                rd_sel = pwm1_map_reg;
            end
            imc_pkg::OFS_MONITOR:
            begin
                rd_sel = input_level_monitor;
            end
            imc_pkg::OFS_MODE:
            begin
                rd_sel = mode_status;
            end
            default:
            begin
                rd_sel = imc_pkg::RD_ZERO;
            end
        endcase
    end

    logic [imc_pkg::DATA_W-1:0] rdata_reg;
    logic [imc_pkg::DATA_W-1:0] rdata_next;

    assign rdata_next = rd_ok ? rd_sel : imc_pkg::RD_ZERO;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg <= imc_pkg::RD_ZERO;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // Per-channel drive combination
    logic [imc_pkg::NUM_CH-1:0] normal_drive;
    logic [imc_pkg::NUM_CH-1:0] fallback_drive;

    genvar c;
    generate
        for (c = 0; c < imc_pkg::NUM_CH; c++)
        begin : g_ch
            assign normal_drive[c] = output_reg[c]
                | (pwm_gen_out[0] & pwm0_map_reg[c])
                | (pwm_gen_out[1] & pwm1_map_reg[c])
                | (in_a & input_a_channel_map_reg[c])
                | (in_b & input_b_channel_map_reg[c]);
            // Fallback ignores maps and uses only the fixed defaults
            assign fallback_drive[c] = (in_a & imc_pkg::RST_MAP_A[c])
                | (in_b & imc_pkg::RST_MAP_B[c]);
        end
    endgenerate

    logic [imc_pkg::NUM_CH-1:0] drive_next;

    assign drive_next = is_normal ? normal_drive :
                        is_fallback ? fallback_drive :
                        {imc_pkg::NUM_CH{1'b0}};

    logic [imc_pkg::NUM_CH-1:0] drive_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            drive_reg <= {imc_pkg::NUM_CH{1'b0}};
        end
        else
        begin
            drive_reg <= drive_next;
        end
    end

    assign channel_drive = drive_reg;

    // Sleep side effects, registered so the pins never glitch
    logic serial_en_reg;
    logic uv_en_reg;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            serial_en_reg <= 1'b1;
            uv_en_reg <= 1'b1;
        end
        else
        begin
            serial_en_reg <= (mode_next != imc_pkg::MODE_SLEEP);
            uv_en_reg <= (mode_next != imc_pkg::MODE_SLEEP);
        end
    end

    assign serial_enable = serial_en_reg;
    assign uv_detect_enable = uv_en_reg;
    assign mode_state = mode_reg;

endmodule : imc_mode_ctrl

//--- imc_pkg.sv
// Constants and types for the input mapping and mode control block
//
// Notes on behaviour
// - After reset input a drives channel 2 and input b drives channel 3.
// - Each direct input has a writable channel map selecting any set of channels.
// - In normal mode each channel is the OR of output bit, mapped PWM and mapped inputs.
// - Direct input levels are readable in the input level monitor register.
// - The input level monitor keeps tracking inputs in fallback mode too.
// - Low-power pin low with any input high gives fallback on default channels.
// - Low-power pin low with both inputs low gives sleep mode.
// - While the low-power pin is low all writable registers stay at their defaults.
// - Sleep disables the supply undervoltage detectors.
// - Sleep ignores register writes, returns zero on reads and drops serial enable.
package imc_pkg;

    localparam int NUM_CH = 8;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int NUM_PINS = 3;
    localparam int NUM_PWM = 2;

    // Position of each pin in the synchronised pin vector
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_LP_N = 2;

    localparam logic [ADDR_W-1:0] OFS_OUTPUT = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_MAP_A = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_MAP_B = 4'h2;
    localparam logic [ADDR_W-1:0] OFS_PWM0_MAP = 4'h3;
    localparam logic [ADDR_W-1:0] OFS_PWM1_MAP = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_MONITOR = 4'h5;
    localparam logic [ADDR_W-1:0] OFS_MODE = 4'h6;

    localparam logic [DATA_W-1:0] RST_OUTPUT = 8'h00;
    localparam logic [DATA_W-1:0] RST_MAP_A = 8'h04;
    localparam logic [DATA_W-1:0] RST_MAP_B = 8'h08;
    localparam logic [DATA_W-1:0] RST_PWM_MAP = 8'h00;
    localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;

    // Monitor register fields
    localparam int MON_A_BIT = 0;
    localparam int MON_B_BIT = 1;

    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b001,
        MODE_FALLBACK = 3'b010,
        MODE_SLEEP = 3'b100
    } imc_mode_t;

endpackage : imc_pkg

//--- imc_pin_if.sv
// Bundle carrying raw pin levels to the synchroniser and back
`timescale 1ns/100ps
interface imc_pin_if;
    logic [imc_pkg::NUM_PINS-1:0] raw;
    logic [imc_pkg::NUM_PINS-1:0] synced;

    modport sync (
        input raw,
        output synced
    );

    modport user (
        output raw,
        input synced
    );
endinterface : imc_pin_if

//--- imc_pin_sync.sv
// Two-stage synchroniser for the control pins
`timescale 1ns/100ps
module imc_pin_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    imc_pin_if.sync pins
);

    logic [imc_pkg::NUM_PINS-1:0] meta_reg;
    logic [imc_pkg::NUM_PINS-1:0] stable_reg;

    // First stage is read only by the second stage
    genvar g;
    generate
        for (g = 0; g < imc_pkg::NUM_PINS; g++)
        begin : g_bit
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_reg[g] <= 1'b0;
                    stable_reg[g] <= 1'b0;
                end
                else
                begin
                    meta_reg[g] <= pins.raw[g];
                    stable_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate

    assign pins.synced = stable_reg;

endmodule : imc_pin_sync

//--- imc_mode_ctrl_assertions.sv
// Checker for the input mapping and mode control block
`timescale 1ns/100ps
module imc_mode_ctrl_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic direct_input_a,
    input wire logic direct_input_b,
    input wire logic low_power_req_n,
    input wire logic [3:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] channel_drive,
    input wire logic serial_enable,
    input wire logic uv_detect_enable,
    input wire logic [2:0] mode_state
);
    // Pin history reset to 0 like the synchroniser, so it stays exact after reset
    logic [2:0] p1_reg, p2_reg, p3_reg, p4_reg;
    logic [1:0] cnt_reg;
    wire logic sl = !p3_reg[2] && p3_reg[1:0] == 2'h0;
    wire logic fb = !p3_reg[2] && p3_reg[1:0] != 2'h0;
    wire logic [2:0] exp_mode = sl ? 3'h4 : (fb ? 3'h2 : 3'h1);
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {p4_reg, p3_reg, p2_reg, p1_reg} <= '0;
            cnt_reg <= 2'h0;
        end
        else
        begin
            {p4_reg, p3_reg, p2_reg} <= {p3_reg, p2_reg, p1_reg};
            p1_reg <= {low_power_req_n, direct_input_b, direct_input_a};
            cnt_reg <= (cnt_reg == 2'h3) ? cnt_reg : cnt_reg + 2'h1;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_mode_follows_pins: assert property (cnt_reg == 2'h3 |-> mode_state == exp_mode)
        else $error("mode state does not follow pins");
    a_serial_off_sleep: assert property (cnt_reg == 2'h3 |-> serial_enable == !sl)
        else $error("serial enable wrong");
    a_uv_off_sleep: assert property (cnt_reg == 2'h3 |-> uv_detect_enable == !sl)
        else $error("undervoltage enable wrong");
    a_fallback_drive: assert property (mode_state == 3'h2 && $past(mode_state) == 3'h2
        && p4_reg[1:0] == p3_reg[1:0] |-> channel_drive == {4'h0, p3_reg[1:0], 2'h0})
        else $error("fallback drive wrong");
    a_sleep_drive_off: assert property (mode_state == 3'h4 && $past(mode_state) == 3'h4
        |-> channel_drive == 8'h00)
        else $error("sleep drive not off");
    a_monitor_read: assert property ($past(reg_rd) && $past(reg_addr) == 4'h5
        && $past(mode_state) != 3'h4 |-> reg_rdata == {6'h0, p3_reg[1:0]})
        else $error("monitor read wrong");
    a_map_held_default: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1
        && $past(mode_state) == 3'h2 |-> reg_rdata == 8'h04)
        else $error("map not at default");
    a_sleep_read_zero: assert property ($past(reg_rd) && $past(mode_state) == 3'h4
        |-> reg_rdata == 8'h00)
        else $error("sleep read not zero");
    c_fallback: cover property (mode_state == 3'h2);
    c_sleep: cover property (mode_state == 3'h4 && reg_rd);
    c_monitor: cover property (reg_rd && reg_addr == 4'h5);
endmodule : imc_mode_ctrl_assertions

bind imc_mode_ctrl imc_mode_ctrl_assertions chk_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .direct_input_a(direct_input_a), .direct_input_b(direct_input_b),
    .low_power_req_n(low_power_req_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .channel_drive(channel_drive), .serial_enable(serial_enable),
    .uv_detect_enable(uv_detect_enable), .mode_state(mode_state));

//--- imc_host_model.sv
// Host model driving the direct input and low-power pins
`timescale 1ns/100ps
module imc_host_model #(
    parameter int HOLD_CYC = 8
) (
    input wire logic sys_clk,
    input wire logic want_a,
    input wire logic want_b,
    input wire logic want_lp_n,
    output logic pin_a,
    output logic pin_b,
    output logic pin_lp_n
);
    int hold_cnt = 0;
    initial
    begin
        pin_a = 1'b0;
        pin_b = 1'b0;
        pin_lp_n = 1'b1;
    end
    // Low-power level may not move again until the transition time has run out
    always @(posedge sys_clk)
    begin
        pin_a <= want_a;
        pin_b <= want_b;
        if (hold_cnt != 0)
            hold_cnt <= hold_cnt - 1;
        else if (want_lp_n != pin_lp_n)
        begin
            pin_lp_n <= want_lp_n;
            hold_cnt <= HOLD_CYC;
        end
    end
endmodule : imc_host_model

//--- imc_mode_ctrl_test.sv
// Self-checking bench for the input mapping and mode control block
`timescale 1ns/100ps
module imc_mode_ctrl_test;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic wa = 1'b0, wb = 1'b0, wlp = 1'b1, pa, pb, plp, wr = 1'b0, rd = 1'b0, se, ue;
    logic [1:0] pwm = 2'h0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, rdata, drive;
    logic [2:0] mode;
    int err_total = 0;
    int check_count = 0;
    initial
    begin
        forever #25 sys_clk = ~sys_clk;
    end
    imc_host_model host_u (.sys_clk(sys_clk), .want_a(wa), .want_b(wb), .want_lp_n(wlp),
        .pin_a(pa), .pin_b(pb), .pin_lp_n(plp));
    imc_mode_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .direct_input_a(pa),
        .direct_input_b(pb), .low_power_req_n(plp), .pwm_gen_out(pwm), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .channel_drive(drive),
        .serial_enable(se), .uv_detect_enable(ue), .mode_state(mode));
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wrr
    task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input string what);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp, what);
        @(posedge sys_clk);
    endtask : rdc
    task automatic settle(input logic [7:0] exp, input string what);
        repeat (2) @(posedge sys_clk);
        #1 chk(drive, exp, what);
        @(posedge sys_clk);
    endtask : settle
    // Pin path has host, sync and drive latency, so wait on mode then settle
    task automatic pins(input logic a, b, lp, input logic [2:0] m, input logic [7:0] exp);
        int n = 0;
        wa <= a;
        wb <= b;
        wlp <= lp;
        while (mode !== m && n < 40)
        begin
            @(posedge sys_clk);
            n++;
        end
        if (mode !== m)
        begin
            err_total++;
            tally_and_finish;
        end
        repeat (4) @(posedge sys_clk);
        settle(exp, "drive");
    endtask : pins
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rdc(4'h1, imc_pkg::RST_MAP_A, "map a");
        rdc(4'h2, imc_pkg::RST_MAP_B, "map b");
        rdc(4'hf, 8'h00, "unmapped");
        rdc(4'h6, 8'h01, "mode");
        pins(1'b1, 1'b0, 1'b1, 3'h1, 8'h04);
        pins(1'b1, 1'b1, 1'b1, 3'h1, 8'h0c);
        wrr(4'h1, 8'h81);
        wrr(4'h2, 8'h02);
        wrr(4'h0, 8'h10);
        wrr(4'h3, 8'h20);
        wrr(4'h4, 8'h40);
        pwm <= 2'h3;
        settle(8'hf3, "or drive");
        rdc(4'h1, 8'h81, "map a back");
        rdc(4'h5, 8'h03, "monitor");
        pins(1'b0, 1'b1, 1'b1, 3'h1, 8'h72);
        rdc(4'h5, 8'h02, "monitor");
        pins(1'b0, 1'b1, 1'b0, 3'h2, 8'h08);
        rdc(4'h6, 8'h02, "mode");
        pins(1'b1, 1'b1, 1'b0, 3'h2, 8'h0c);
        rdc(4'h5, 8'h03, "monitor");
        wrr(4'h1, 8'hff);
        rdc(4'h1, imc_pkg::RST_MAP_A, "map held");
        pins(1'b0, 1'b0, 1'b0, 3'h4, 8'h00);
        #1 chk({7'h0, se}, 8'h00, "serial");
        chk({7'h0, ue}, 8'h00, "uv");
        @(posedge sys_clk);
        rdc(4'h5, 8'h00, "sleep read");
        // Output and PWM maps came back at their defaults, so nothing drives
        pins(1'b0, 1'b0, 1'b1, 3'h1, 8'h00);
        rdc(4'h1, imc_pkg::RST_MAP_A, "map reset");
        #1 chk({7'h0, se}, 8'h01, "serial");
        chk({7'h0, ue}, 8'h01, "uv");
        tally_and_finish;
    end
endmodule : imc_mode_ctrl_test
